/* core/twm_params.svh */
`ifndef TWM_PARAMS_SVH
`define TWM_PARAMS_SVH

// register byte offsets
`define TWM_OFF_UNIT_EN     8'h00
`define TWM_OFF_PRESCALE    8'h04
`define TWM_OFF_MODE        8'h08
`define TWM_OFF_TRIGGER     8'h0c
`define TWM_OFF_ENABLE_STS  8'h10
`define TWM_OFF_CHAN_STS    8'h14
`define TWM_OFF_DATA        8'h18
`define TWM_OFF_COUNT       8'h1c
`define TWM_OFF_OUT_CTRL    8'h20

// unit enable register
`define TWM_UNIT_EN_BIT     0

// trigger register (write only, self clearing)
`define TWM_TRIG_START_BIT  0
`define TWM_TRIG_STOP_BIT   1
`define TWM_TRIG_HSTART_BIT 2

// enable status register
`define TWM_STS_EN_BIT      0
`define TWM_STS_HEN_BIT     1

// channel status register
`define TWM_OVF_BIT         0

// output control register
`define TWM_OUT_EN_BIT      0
`define TWM_OUT_MODE_BIT    1
`define TWM_OUT_LEVEL_BIT   2
`define TWM_OUT_VALUE_BIT   3
`define TWM_FILT_EN_BIT     4
`define TWM_OUT_CTRL_MASK   5'h1f

// mode register fields
`define TWM_MODE_CKS_HI     15
`define TWM_MODE_CKS_LO     14
`define TWM_MODE_BIT11      11
`define TWM_MODE_STS_HI     10
`define TWM_MODE_STS_LO     8
`define TWM_MODE_CIS_HI     7
`define TWM_MODE_CIS_LO     6
`define TWM_MODE_MD_HI      3
`define TWM_MODE_MD_LO      1
`define TWM_MODE_WMASK      16'hd7cf

// encodings
`define TWM_MD_CAPTURE_ONE  3'b110
`define TWM_MD_ONE_COUNT    3'b100
`define TWM_CIS_FALLING     2'b00
`define TWM_CIS_RISING      2'b01
`define TWM_CIS_LOW_WIDTH   2'b10
`define TWM_CIS_HIGH_WIDTH  2'b11

// counter limits and reset values
`define TWM_COUNT_ZERO      16'h0000
`define TWM_COUNT_FULL      16'hffff
`define TWM_PRESCALE_RESET  16'h0000
`define TWM_MODE_RESET      16'h0000
`define TWM_DATA_RESET      16'h0000
`define TWM_DEFAULT_CHANNEL 1

`endif

/* core/twm_pkg.sv */
package twm_pkg;

    // channel sequencing
    typedef enum logic [2:0] {
        CH_STOPPED,
        CH_WAIT_START,
        CH_MEASURE,
        CH_WAIT_EDGE,
        CH_COUNT_DOWN
    } twm_state_t;

    // whole register state of the timer block
    typedef struct packed {
        logic        unit_en;
        logic [15:0] prescale;
        logic [15:0] mode;
        logic [4:0]  out_ctrl;
        logic [15:0] data;
        logic [15:0] count;
        logic        enable_sts;
        logic        hbyte_enable_sts;
        logic        overflow_flag;
        logic        ovf_seen;
        twm_state_t  state;
        logic [15:0] div_cnt;
        logic        pin_raw;
        logic        pin_filt;
        logic        pin_prev;
        logic        irq;
        logic        out_pin;
        logic        pready;
        logic        pslverr;
        logic [31:0] prdata;
    } twm_regs_t;

endpackage : twm_pkg

/* core/twm_timer.sv */
// Added by the designer: the address map and the APB slave port.
`timescale 1ns/1ps
`include "twm_params.svh"

module twm_timer
    import twm_pkg::*;
#(
    parameter int CHANNEL = `TWM_DEFAULT_CHANNEL
) (
    // clock and reset
    input  wire logic        REF_CLK,
    input  wire logic        RST_N,
    // apb slave
    input  wire logic        PSEL,
    input  wire logic        PENABLE,
    input  wire logic        PWRITE,
    input  wire logic [7:0]  PADDR,
    input  wire logic [31:0] PWDATA,
    output logic      [31:0] PRDATA,
    output logic             PREADY,
    output logic             PSLVERR,
    // timer pins and event
    input  wire logic        TIMER_INPUT_PIN,
    output logic             CHANNEL_OUTPUT_PIN,
    output logic             CHANNEL_IRQ
);

    twm_regs_t s_reg;
    twm_regs_t s_next;

    // which meaning bit 11 has on this channel
    localparam logic IS_SPLIT_CH = (CHANNEL == 1) || (CHANNEL == 3);
    localparam logic IS_LEAD_CH  = (CHANNEL == 2) || (CHANNEL == 4) ||
                                   (CHANNEL == 6);

    // tick mask for a 4-bit rate select: fires every 2^sel cycles;
    // the slowest rate is one tick per 32768 cycles, since the select
    // field is four bits and the shared divider is sixteen bits wide
    function automatic logic [15:0] rate_mask(input logic [3:0] sel);
        rate_mask = 16'((16'h0001 << sel) - 16'h0001);
    endfunction : rate_mask

    // decoded bus request
    logic        access;
    logic        wr_go;
    logic        rd_go;
    logic        mapped;

    // mode fields and the selected count clock
    logic [2:0]  md;
    logic [1:0]  cis;
    logic [1:0]  cks;
    logic        split_on;
    logic [3:0]  tick_all;
    logic        tick;

    // input edges as seen at count ticks
    logic        pin_now;
    logic        start_edge;
    logic        capture_edge;
    logic        delay_edge;
    logic        rise;
    logic        fall;

    // software triggers and the masked mode write
    logic        start_trig;
    logic        stop_trig;
    logic        hstart_trig;
    logic [31:0] rd_val;
    logic [15:0] mode_wr;

    // a transfer is accepted on the edge at which the registered ready
    // is already high, so a write lands one cycle after the wait state;
    // read data is latched a cycle early so that it stands with ready
    always_comb begin
        access = PSEL && PENABLE;
        wr_go  = access && s_reg.pready && PWRITE;
        rd_go  = access && !s_reg.pready && !PWRITE;
    end

    // address decode, unmapped addresses answer with pslverr; only the
    // low bits of each word are used and the rest read as zero
    always_comb begin
        mapped = 1'b1;
        rd_val = 32'h0000_0000;
        if (PADDR == `TWM_OFF_UNIT_EN) begin
            rd_val[`TWM_UNIT_EN_BIT] = s_reg.unit_en;
        end else if (PADDR == `TWM_OFF_PRESCALE) begin
            rd_val[15:0] = s_reg.prescale;
        end else if (PADDR == `TWM_OFF_MODE) begin
            rd_val[15:0] = s_reg.mode;
        end else if (PADDR == `TWM_OFF_TRIGGER) begin
            rd_val = 32'h0000_0000; // trigger bits always read as zero
        end else if (PADDR == `TWM_OFF_ENABLE_STS) begin
            rd_val[`TWM_STS_EN_BIT]  = s_reg.enable_sts;
            rd_val[`TWM_STS_HEN_BIT] = s_reg.hbyte_enable_sts;
        end else if (PADDR == `TWM_OFF_CHAN_STS) begin
            rd_val[`TWM_OVF_BIT] = s_reg.overflow_flag;
        end else if (PADDR == `TWM_OFF_DATA) begin
            rd_val[15:0] = s_reg.data;
        end else if (PADDR == `TWM_OFF_COUNT) begin
            rd_val[15:0] = s_reg.count;
        end else if (PADDR == `TWM_OFF_OUT_CTRL) begin
            rd_val[4:0] = s_reg.out_ctrl;
        end else begin
            mapped = 1'b0;
        end
    end

    // mode fields and clock selection
    always_comb begin
        md       = s_reg.mode[`TWM_MODE_MD_HI:`TWM_MODE_MD_LO];
        cis      = s_reg.mode[`TWM_MODE_CIS_HI:`TWM_MODE_CIS_LO];
        split_on = IS_SPLIT_CH && s_reg.mode[`TWM_MODE_BIT11];
        cks      = s_reg.mode[`TWM_MODE_CKS_HI:`TWM_MODE_CKS_LO];
        if (!split_on) begin
            cks[0] = 1'b0; // only clocks a and b unless split
        end
        // a shared free-running divider keeps all four clocks in phase
        // and costs one counter instead of four; it stops while off
        for (int i = 0; i < 4; i++) begin
            tick_all[i] = s_reg.unit_en &&
                ((s_reg.div_cnt & rate_mask(s_reg.prescale[i*4 +: 4])) ==
                 rate_mask(s_reg.prescale[i*4 +: 4]));
        end
        // cks 00 a, 10 b, 01 c, 11 d
        tick = tick_all[{cks[0], cks[1]}];
    end

    // edge detection on the input, sampled only at ticks; a measured
    // width therefore carries an error of up to one count clock
    always_comb begin
        pin_now = s_reg.out_ctrl[`TWM_FILT_EN_BIT] ? s_reg.pin_filt
                                                   : s_reg.pin_raw;
        rise    = tick && pin_now && !s_reg.pin_prev;
        fall    = tick && !pin_now && s_reg.pin_prev;
        start_edge   = (cis == `TWM_CIS_HIGH_WIDTH) ? rise : fall;
        capture_edge = (cis == `TWM_CIS_HIGH_WIDTH) ? fall : rise;
        if (cis == `TWM_CIS_FALLING) begin
            delay_edge = fall;
        end else if (cis == `TWM_CIS_RISING) begin
            delay_edge = rise;
        end else begin
            delay_edge = rise || fall;
        end
    end

    // triggers only exist on the accepting edge of a trigger write;
    // nothing is stored, so the trigger register always reads zero
    always_comb begin
        start_trig  = wr_go && s_reg.unit_en &&
                      PADDR == `TWM_OFF_TRIGGER &&
                      PWDATA[`TWM_TRIG_START_BIT];
        stop_trig   = wr_go && s_reg.unit_en &&
                      PADDR == `TWM_OFF_TRIGGER &&
                      PWDATA[`TWM_TRIG_STOP_BIT];
        hstart_trig = wr_go && s_reg.unit_en &&
                      PADDR == `TWM_OFF_TRIGGER &&
                      PWDATA[`TWM_TRIG_HSTART_BIT];
        mode_wr = PWDATA[15:0] & `TWM_MODE_WMASK;
        if (!(IS_SPLIT_CH || IS_LEAD_CH)) begin
            mode_wr[`TWM_MODE_BIT11] = 1'b0;
        end else begin
            mode_wr[`TWM_MODE_BIT11] = PWDATA[`TWM_MODE_BIT11];
        end
    end

    // next-state logic for the whole block
    always_comb begin
        s_next     = s_reg;
        s_next.irq = 1'b0;

        // apb: one wait state, then answer for a single cycle; a master
        // that drops the request early simply gets no answer
        s_next.pready  = access && !s_reg.pready;
        s_next.pslverr = access && !s_reg.pready && !mapped;
        if (rd_go) begin
            s_next.prdata = mapped ? rd_val : 32'h0000_0000;
        end

        // input sampling; filter wants two equal samples in a row, so a
        // one-cycle glitch never reaches the edge detector, at the cost
        // of one more cycle of latency on both edges alike
        s_next.pin_raw = TIMER_INPUT_PIN;
        if (s_reg.pin_raw == TIMER_INPUT_PIN) begin
            s_next.pin_filt = s_reg.pin_raw;
        end
        if (tick) begin
            s_next.pin_prev = pin_now;
        end

        // prescaler runs only while the array is clocked; the wrap of the
        // sixteen-bit count lands on every tick boundary, so no rate skips
        s_next.div_cnt = 16'(s_reg.div_cnt + 16'h0001);

        // register writes, blocked while the array is off; writes to the
        // mode and output bits are not refused while running
        if (wr_go && mapped && s_reg.unit_en) begin
            if (PADDR == `TWM_OFF_PRESCALE) begin
                s_next.prescale = PWDATA[15:0];
            end else if (PADDR == `TWM_OFF_MODE) begin
                s_next.mode = mode_wr;
            end else if (PADDR == `TWM_OFF_DATA) begin
                s_next.data = PWDATA[15:0];
            end else if (PADDR == `TWM_OFF_OUT_CTRL) begin
                s_next.out_ctrl = PWDATA[4:0] & `TWM_OUT_CTRL_MASK;
            end
        end

        // channel sequencing
        case (s_reg.state)
            CH_STOPPED: begin
                // only the two built modes accept a start; others ignore it
                if (start_trig && md == `TWM_MD_CAPTURE_ONE) begin
                    s_next.enable_sts = 1'b1;
                    s_next.state      = CH_WAIT_START;
                end else if (start_trig && md == `TWM_MD_ONE_COUNT) begin
                    s_next.enable_sts = 1'b1;
                    s_next.state      = CH_WAIT_EDGE;
                end
            end
            CH_WAIT_START: begin
                // a start trigger while enabled is ignored here and in
                // the measuring state, so a running measure is kept
                if (start_edge) begin
                    s_next.count    = `TWM_COUNT_ZERO;
                    s_next.ovf_seen = 1'b0;
                    s_next.state    = CH_MEASURE;
                end
            end
            CH_MEASURE: begin
                // capture wins over a count tick in the same cycle; the
                // count then stops one above the captured value
                if (capture_edge) begin
                    s_next.data          = s_reg.count;
                    s_next.irq           = 1'b1;
                    s_next.overflow_flag = s_reg.ovf_seen;
                    s_next.count = 16'(s_reg.count + 16'h0001);
                    s_next.state = CH_WAIT_START;
                end else if (tick) begin
                    s_next.count = 16'(s_reg.count + 16'h0001);
                    if (s_reg.count == `TWM_COUNT_FULL) begin
                        s_next.ovf_seen = 1'b1;
                    end
                end
            end
            CH_WAIT_EDGE, CH_COUNT_DOWN: begin
                // a fresh trigger reloads; data is only read here
                // an edge during a count restarts it rather than queue it
                if (delay_edge || start_trig) begin
                    s_next.count = s_reg.data;
                    s_next.state = CH_COUNT_DOWN;
                end else if (s_reg.state == CH_COUNT_DOWN && tick) begin
                    if (s_reg.count == `TWM_COUNT_ZERO) begin
                        s_next.irq   = 1'b1;
                        s_next.state = CH_WAIT_EDGE; // hold zero
                    end else begin
                        s_next.count = 16'(s_reg.count - 16'h0001);
                    end
                end
            end
            default: begin
                s_next.state = CH_STOPPED;
            end
        endcase

        // high byte start on split channels only the status bit
        // exists here, as the 8-bit half timer itself is not built
        if (hstart_trig && split_on && md == `TWM_MD_ONE_COUNT) begin
            s_next.hbyte_enable_sts = 1'b1;
        end

        // stop keeps count and overflow flag as they are; it is applied
        // after the sequencer, so a write carrying start and stop
        // together leaves the channel stopped
        if (stop_trig) begin
            s_next.enable_sts       = 1'b0;
            s_next.hbyte_enable_sts = 1'b0;
            s_next.state            = CH_STOPPED;
        end

        // output pin follows only the software value bit; counting
        // never reaches it since output modes are not built here
        s_next.out_pin = s_reg.out_ctrl[`TWM_OUT_VALUE_BIT];

        // unit enable is always writable, even while the array is off,
        // since it is the only way back to a clocked array
        if (wr_go && PADDR == `TWM_OFF_UNIT_EN) begin
            s_next.unit_en = PWDATA[`TWM_UNIT_EN_BIT];
        end

        // array off: everything but the bus answer and the input sampling goes back
        // to reset; the bus answer is spared so transfers made while off, such as
        // the enabling write, still complete on the bus
        if (!s_reg.unit_en) begin
            s_next.prescale         = `TWM_PRESCALE_RESET;
            s_next.mode             = `TWM_MODE_RESET;
            s_next.out_ctrl         = 5'h00;
            s_next.data             = `TWM_DATA_RESET;
            s_next.count            = `TWM_COUNT_ZERO;
            s_next.enable_sts       = 1'b0;
            s_next.hbyte_enable_sts = 1'b0;
            s_next.overflow_flag    = 1'b0;
            s_next.ovf_seen         = 1'b0;
            s_next.state            = CH_STOPPED;
            s_next.div_cnt          = 16'h0000; // no clock while off
            // edge history follows the pin, so enabling the array with
            // the line already high shows no false rising edge
            s_next.pin_prev         = pin_now;
            s_next.irq              = 1'b0;
            s_next.out_pin          = 1'b0;
        end
        // the disabling write stops the channel at once, one cycle
        // before the rest of the state is cleared
        if (s_reg.unit_en && !s_next.unit_en) begin
            s_next.state      = CH_STOPPED;
            s_next.enable_sts = 1'b0;
        end
    end

    // single state register; reset gives the values that a cleared
    // unit enable forces, so both ways in leave the channel stopped
    always_ff @(posedge REF_CLK or negedge RST_N) begin
        if (!RST_N) begin
            s_reg <= '{
                state:   CH_STOPPED,
                prescale: `TWM_PRESCALE_RESET,
                mode:    `TWM_MODE_RESET,
                data:    `TWM_DATA_RESET,
                count:   `TWM_COUNT_ZERO,
                default: '0
            };
        end else begin
            s_reg <= s_next;
        end
    end

    // outputs straight from flip-flops; the interrupt is a one-cycle
    // pulse, so any consumer must take it on that same edge
    always_comb begin
        PRDATA             = s_reg.prdata;
        PREADY             = s_reg.pready;
        PSLVERR            = s_reg.pslverr;
        CHANNEL_IRQ        = s_reg.irq;
        CHANNEL_OUTPUT_PIN = s_reg.out_pin;
    end

endmodule : twm_timer

/* verif/twm_sig_src.sv */
`timescale 1ns/1ps
module twm_sig_src (
    // clock
    input  wire logic        clk,
    // pulse request from the bench
    input  wire logic        idle_lvl,
    input  wire logic        go,
    input  wire logic [16:0] len,
    // line towards the timer input
    output logic             pin
);
    logic [16:0] left_reg = 17'h00000;

    // line rests at idle level, inverts for len cycles per request
    always_ff @(posedge clk) begin
        if (go) begin
            left_reg <= len;
        end else if (left_reg != 17'h00000) begin
            left_reg <= left_reg - 17'h00001;
        end
        pin <= (left_reg != 17'h00000) ? ~idle_lvl : idle_lvl;
    end
endmodule : twm_sig_src

/* verif/twm_timer_checker.sv */
`timescale 1ns/1ps
module twm_timer_checker
    import twm_pkg::*;
(
    // clock and reset
    input wire logic        REF_CLK,
    input wire logic        RST_N,
    // apb
    input wire logic        PSEL,
    input wire logic        PENABLE,
    input wire logic        PWRITE,
    input wire logic [7:0]  PADDR,
    input wire logic [31:0] PWDATA,
    input wire logic [31:0] PRDATA,
    input wire logic        PREADY,
    input wire logic        PSLVERR,
    // pins
    input wire logic        TIMER_INPUT_PIN,
    input wire logic        CHANNEL_OUTPUT_PIN,
    input wire logic        CHANNEL_IRQ
);
    logic unit_en_reg;
    logic wr_done;

    default clocking @(posedge REF_CLK); endclocking
    default disable iff (!RST_N);

    assign wr_done = PSEL && PENABLE && PREADY && PWRITE;

    // shadow of unit enable, so reads while off can be judged
    always_ff @(posedge REF_CLK or negedge RST_N) begin
        if (!RST_N) begin
            unit_en_reg <= 1'b0;
        end else if (wr_done && PADDR == 8'h00) begin
            unit_en_reg <= PWDATA[0];
        end
    end

    sequence s_access;
        PSEL && PENABLE && !PREADY ##1 PREADY;
    endsequence

    a_one_wait: assert property ((PSEL && !PENABLE) |=> s_access)
        else $error("ready not in second access cycle");
    a_ready_pulse: assert property (PREADY |=> !PREADY)
        else $error("ready longer than one cycle");
    a_err_mapped: assert property ((PREADY && PADDR[1:0] == 2'b00)
        |-> (PSLVERR == (PADDR > 8'h20)))
        else $error("error flag wrong for address");
    a_err_reads_zero: assert property ((PREADY && PSLVERR && !PWRITE)
        |-> PRDATA == 32'h0)
        else $error("unmapped read not zero");
    a_trig_reads_zero: assert property (
        (PREADY && !PWRITE && PADDR == 8'h0c) |-> PRDATA == 32'h0)
        else $error("trigger register read not zero");
    a_off_reads_zero: assert property (
        (PREADY && !PWRITE && !unit_en_reg) |-> PRDATA == 32'h0)
        else $error("register not cleared while unit off");
    a_irq_pulse: assert property (CHANNEL_IRQ |=> !CHANNEL_IRQ)
        else $error("interrupt longer than one cycle");
    a_irq_off: assert property (
        (!unit_en_reg && !$past(unit_en_reg) && !$past(unit_en_reg, 2))
        |-> !CHANNEL_IRQ)
        else $error("interrupt while unit off");
    a_pin_quiet: assert property ($changed(CHANNEL_OUTPUT_PIN)
        |-> ($past(wr_done, 2) || $past(wr_done, 3)))
        else $error("output pin moved without a write");
endmodule : twm_timer_checker

bind twm_timer twm_timer_checker u_chk (
    .REF_CLK            (REF_CLK),
    .RST_N              (RST_N),
    .PSEL               (PSEL),
    .PENABLE            (PENABLE),
    .PWRITE             (PWRITE),
    .PADDR              (PADDR),
    .PWDATA             (PWDATA),
    .PRDATA             (PRDATA),
    .PREADY             (PREADY),
    .PSLVERR            (PSLVERR),
    .TIMER_INPUT_PIN    (TIMER_INPUT_PIN),
    .CHANNEL_OUTPUT_PIN (CHANNEL_OUTPUT_PIN),
    .CHANNEL_IRQ        (CHANNEL_IRQ)
);

/* verif/tb_timer_width_measure_delay_count.sv */
`timescale 1ns/1ps
module tb_timer_width_measure_delay_count
    import twm_pkg::*;
;
    logic        ref_clk = 1'b0;
    logic        rst_n = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        pin;
    logic        out_pin;
    logic        irq;
    logic        src_idle = 1'b0;
    logic        src_go = 1'b0;
    logic [16:0] src_len = 17'h00000;
    logic [31:0] q;
    logic        err;
    int          failures = 0;
    int          checks_done = 0;
    int          cyc = 0;
    int          irq_n = 0;
    int          irq_at = 0;
    int          go_at = 0;
    int          d3;
    int          d40;
    int          n0;

    always #12.5 ref_clk = ~ref_clk;

    twm_timer u_dut (
        .REF_CLK            (ref_clk),
        .RST_N              (rst_n),
        .PSEL               (psel),
        .PENABLE            (penable),
        .PWRITE             (pwrite),
        .PADDR              (paddr),
        .PWDATA             (pwdata),
        .PRDATA             (prdata),
        .PREADY             (pready),
        .PSLVERR            (pslverr),
        .TIMER_INPUT_PIN    (pin),
        .CHANNEL_OUTPUT_PIN (out_pin),
        .CHANNEL_IRQ        (irq)
    );

    twm_sig_src u_src (
        .clk      (ref_clk),
        .idle_lvl (src_idle),
        .go       (src_go),
        .len      (src_len),
        .pin      (pin)
    );

    // cycle count, event log and hang guard (long capture needs 66k)
    always @(posedge ref_clk) begin
        cyc++;
        if (src_go === 1'b1) begin
            go_at = cyc;
        end
        if (irq === 1'b1) begin
            irq_n++;
            irq_at = cyc;
        end
        if (cyc == 90000) begin
            failures++;
            finish_test();
        end
    end

    task automatic finish_test();
        $display("checks %0d failures %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : finish_test

    task automatic chk(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
        checks_done++;
        if (g !== e) begin
            failures++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    // one apb transfer; held until ready is sampled, then one idle cycle
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        do begin
            @(posedge ref_clk);
        end while (pready !== 1'b1);
        q = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge ref_clk);
    endtask : apb

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask : wr

    task automatic rc(input logic [7:0] a, input logic [31:0] e,
                      input string nm);
        apb(1'b0, a, 32'h0);
        chk(nm, e, q);
    endtask : rc

    task automatic fire(input int l);
        src_len <= l[16:0];
        src_go <= 1'b1;
        @(posedge ref_clk);
        src_go <= 1'b0;
    endtask : fire

    // main sequence
    initial begin
        repeat (12) @(posedge ref_clk);
        rst_n <= 1'b1;
        @(posedge ref_clk);
        wr(8'h18, 32'h1234);
        rc(8'h18, 32'h0, "data while off");
        wr(8'h00, 32'h1);
        rc(8'h10, 32'h0, "enable status");
        wr(8'h18, 32'h5a5a);
        rc(8'h18, 32'h5a5a, "data");
        wr(8'h08, 32'h4800);
        rc(8'h08, 32'h4800, "mode split");
        wr(8'h04, 32'h21);
        rc(8'h04, 32'h21, "prescale");
        wr(8'h04, 32'h0);
        rc(8'h40, 32'h0, "unmapped");
        chk("unmapped error", 32'h1, {31'h0, err});
        wr(8'h20, 32'h8);
        @(posedge ref_clk);
        chk("value bit", 32'h1, {31'h0, out_pin});
        wr(8'h20, 32'h0);
        $display("setup test done");
        // high width with a wrap first, then a short low width
        for (int i = 0; i < 2; i++) begin
            wr(8'h0c, 32'h2);
            src_idle <= i[0];
            wr(8'h08, {24'h0, 1'b1, ~i[0], 6'b001100});
            n0 = irq_n;
            wr(8'h0c, 32'h1);
            rc(8'h10, 32'h1, "width enable");
            rc(8'h0c, 32'h0, "trigger clears");
            fire(i ? 5 : 65540);
            wr(8'h0c, 32'h1);
            repeat (i ? 25 : 65560) @(posedge ref_clk);
            chk("capture irq", n0 + 1, irq_n);
            rc(8'h18, i ? 32'h4 : 32'h3, "capture");
            rc(8'h14, i ? 32'h0 : 32'h1, "overflow");
            rc(8'h1c, i ? 32'h5 : 32'h4, "held");
            $display("width test %0d done", i);
        end
        wr(8'h0c, 32'h2);
        rc(8'h10, 32'h0, "stopped");
        rc(8'h1c, 32'h5, "count kept");
        chk("output pin", 32'h0, {31'h0, out_pin});
        $display("stop test done");
        src_idle <= 1'b0;
        // prescaled clock a every 2 cycles with the filter on: 8 cycles
        // high are 4 ticks whatever the divider phase, so capture is 3
        wr(8'h04, 32'h1);
        wr(8'h20, 32'h10);
        wr(8'h08, 32'hcc);
        wr(8'h0c, 32'h1);
        fire(8);
        repeat (30) @(posedge ref_clk);
        rc(8'h18, 32'h3, "ticked width");
        wr(8'h0c, 32'h2);
        wr(8'h04, 32'h0);
        wr(8'h20, 32'h0);
        $display("prescale test done");
        wr(8'h08, 32'h48);
        wr(8'h18, 32'h3);
        wr(8'h0c, 32'h1);
        rc(8'h10, 32'h1, "delay enable");
        n0 = irq_n;
        fire(2);
        repeat (40) @(posedge ref_clk);
        d3 = irq_at - go_at;
        chk("delay irq", n0 + 1, irq_n);
        rc(8'h1c, 32'h0, "count at zero");
        wr(8'h18, 32'h28);
        fire(2);
        repeat (80) @(posedge ref_clk);
        d40 = irq_at - go_at;
        chk("interval", 32'h25, d40 - d3);
        fire(2);
        wr(8'h18, 32'h3);
        repeat (80) @(posedge ref_clk);
        chk("old data used", d40, irq_at - go_at);
        fire(2);
        repeat (40) @(posedge ref_clk);
        chk("new data used", d3, irq_at - go_at);
        n0 = irq_n;
        wr(8'h0c, 32'h1);
        repeat (40) @(posedge ref_clk);
        chk("software start", n0 + 1, irq_n);
        $display("delay test done");
        wr(8'h00, 32'h0);
        rc(8'h18, 32'h0, "data cleared");
        rc(8'h08, 32'h0, "mode cleared");
        wr(8'h00, 32'h1);
        rc(8'h10, 32'h0, "stopped after enable");
        $display("unit off test done");
        finish_test();
    end
endmodule : tb_timer_width_measure_delay_count
